// File: hdl/phy_regs_pkg.sv
package phy_regs_pkg;

  localparam logic [7:0] status_offset = 8'hb8;
  localparam logic [7:0] id_high_offset = 8'hbc;
  localparam logic [7:0] id_low_offset = 8'hc0;
  localparam logic [7:0] adv_offset = 8'hc4;
  localparam logic [7:0] partner_offset = 8'hc8;

  localparam int ten_full_duplex_capable_bit = 12;
  localparam int ten_half_duplex_capable_bit = 11;
  localparam int autoneg_complete_bit = 5;
  localparam int remote_fault_flag_bit = 4;
  localparam int autoneg_capable_bit = 3;
  localparam int link_status_bit = 2;
  localparam int jabber_latched_bit = 1;
  localparam int extended_regs_present_bit = 0;

  localparam int oui_lower_bits_lsb = 10;
  localparam int model_lsb = 4;
  localparam int revision_lsb = 0;

  localparam logic [15:0] adv_reset = 16'h05e1;
  localparam logic [15:0] adv_write_mask = 16'h25e0;
  localparam logic [4:0] selector_field = 5'h01;

  localparam logic [15:0] partner_keep_mask = 16'he7ff;
  localparam logic [15:0] partner_reset = 16'h0000;

endpackage : phy_regs_pkg

// File: hdl/status_latch_if.sv
`timescale 1ns/100ps
interface status_latch_if;
  logic remote_fault_evt;
  logic link_up;
  logic jabber_evt;
  logic speed_10;
  logic read_clear;
  logic remote_fault_flag;
  logic link_status;
  logic jabber_latched;

  modport owner (
    output remote_fault_evt,
    output link_up,
    output jabber_evt,
    output speed_10,
    output read_clear,
    input remote_fault_flag,
    input link_status,
    input jabber_latched
  );

  modport latch (
    input remote_fault_evt,
    input link_up,
    input jabber_evt,
    input speed_10,
    input read_clear,
    output remote_fault_flag,
    output link_status,
    output jabber_latched
  );
endinterface : status_latch_if

// File: hdl/status_latches.sv
`timescale 1ns/100ps
module status_latches (
  input wire logic clk_i,
  input wire logic rst_n_i,
  status_latch_if.latch lat
);

  logic link_fail_seen;

  ////////////////////////////////////////////////////////////////////////////
  // An event in the clearing cycle wins, so no remote fault, and no jabber while speed_10 is high, is ever lost.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lat.remote_fault_flag <= 1'b0;
    else
      lat.remote_fault_flag <= lat.remote_fault_evt |
        (lat.remote_fault_flag & ~lat.read_clear);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lat.jabber_latched <= 1'b0;
    else
      lat.jabber_latched <= (lat.jabber_evt & lat.speed_10) |
        (lat.jabber_latched & ~lat.read_clear);
  end

  ////////////////////////////////////////////////////////////////////////////
  // A failure stays visible until read, then the live link shows again.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      link_fail_seen <= 1'b0;
    else
      link_fail_seen <= ~lat.link_up |
        (link_fail_seen & ~lat.read_clear);
  end

  assign lat.link_status = lat.link_up & ~link_fail_seen;

endmodule : status_latches

// File: hdl/phy_status_id_autoneg_regs.sv
`timescale 1ns/100ps
module phy_status_id_autoneg_regs #(
  parameter logic [15:0] oui_upper_bits = 16'h5a3c, // Arbitrary value.
  parameter logic [5:0] oui_lower_bits = 6'h15, // Arbitrary value.
  parameter logic [5:0] model_number = 6'h0a, // Arbitrary value.
  parameter logic [3:0] revision_number = 4'h3 // Arbitrary value.
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] csr_addr_i,
  input wire logic csr_rd_i,
  input wire logic csr_wr_i,
  input wire logic [31:0] csr_wdata_i,
  output logic [31:0] csr_rdata_o,
  output logic csr_rd_ack_o,
  input wire logic xcvr_reset_i,
  input wire logic autoneg_restart_i,
  input wire logic autoneg_done_i,
  input wire logic remote_fault_i,
  input wire logic link_up_i,
  input wire logic jabber_i,
  input wire logic speed_10_i,
  input wire logic partner_word_valid_i,
  input wire logic [15:0] partner_word_i,
  output logic [15:0] adv_word_o,
  output logic autoneg_complete_o
);

  logic rst_sync_a;
  logic rst_n;
  logic [15:0] adv_bits;
  logic [15:0] partner_bits;
  logic autoneg_complete;
  logic [15:0] next_rdata;
  logic status_read;

  status_latch_if lat ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset is released through two flops so no register leaves reset
  // on a partial edge.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync_a <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_sync_a <= 1'b1;
      rst_n <= rst_sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] offset);
    hit = (addr == offset);
  endfunction : hit

  assign status_read = csr_rd_i & hit(csr_addr_i, phy_regs_pkg::status_offset);

  ////////////////////////////////////////////////////////////////////////////
  // Latched status flags live in their own module.
  assign lat.remote_fault_evt = remote_fault_i;
  assign lat.link_up = link_up_i;
  assign lat.jabber_evt = jabber_i;
  assign lat.speed_10 = speed_10_i;
  assign lat.read_clear = status_read;

  status_latches u_latches (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .lat(lat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Completion drops at once on a restart, before the new result arrives.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      autoneg_complete <= 1'b0;
    else if (xcvr_reset_i | autoneg_restart_i)
      autoneg_complete <= 1'b0;
    else
      autoneg_complete <= autoneg_done_i;
  end

  assign autoneg_complete_o = autoneg_complete;

  ////////////////////////////////////////////////////////////////////////////
  // Only the ability flags take writes; the fixed fields are rebuilt
  // from constants so a write can never disturb them.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      adv_bits <= phy_regs_pkg::adv_reset & phy_regs_pkg::adv_write_mask;
    else if (xcvr_reset_i)
      adv_bits <= phy_regs_pkg::adv_reset & phy_regs_pkg::adv_write_mask;
    else if (csr_wr_i & hit(csr_addr_i, phy_regs_pkg::adv_offset))
      adv_bits <= csr_wdata_i[15:0] & phy_regs_pkg::adv_write_mask;
  end

  // keep the writable flags; keeps bits 15 and 9 at zero.
  assign adv_word_o = adv_bits |
                      {11'h000, phy_regs_pkg::selector_field};

  ////////////////////////////////////////////////////////////////////////////
  // Partner bits hold the last received code word with bits 12 and 11 cleared; a restart or
  // transceiver reset forgets it so stale abilities are never shown.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      partner_bits <= phy_regs_pkg::partner_reset;
    else if (xcvr_reset_i | autoneg_restart_i)
      partner_bits <= phy_regs_pkg::partner_reset;
    else if (partner_word_valid_i)
      partner_bits <= partner_word_i & phy_regs_pkg::partner_keep_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (csr_addr_i)
      phy_regs_pkg::status_offset:
      begin
        next_rdata[phy_regs_pkg::ten_full_duplex_capable_bit] = 1'b1;
        next_rdata[phy_regs_pkg::ten_half_duplex_capable_bit] = 1'b1;
        next_rdata[phy_regs_pkg::autoneg_complete_bit] =
          autoneg_complete;
        next_rdata[phy_regs_pkg::remote_fault_flag_bit] =
          lat.remote_fault_flag;
        next_rdata[phy_regs_pkg::autoneg_capable_bit] = 1'b1;
        next_rdata[phy_regs_pkg::link_status_bit] = lat.link_status;
        next_rdata[phy_regs_pkg::jabber_latched_bit] =
          lat.jabber_latched;
        next_rdata[phy_regs_pkg::extended_regs_present_bit] = 1'b1;
      end
      phy_regs_pkg::id_high_offset:
        next_rdata = oui_upper_bits;
      phy_regs_pkg::id_low_offset:
      begin
        next_rdata[15:phy_regs_pkg::oui_lower_bits_lsb] =
          oui_lower_bits;
        next_rdata[phy_regs_pkg::oui_lower_bits_lsb - 1:
                   phy_regs_pkg::model_lsb] = model_number;
        next_rdata[phy_regs_pkg::model_lsb - 1:
                   phy_regs_pkg::revision_lsb] = revision_number;
      end
      phy_regs_pkg::adv_offset:
        next_rdata = adv_word_o;
      phy_regs_pkg::partner_offset:
        next_rdata = partner_bits;
      default:
        next_rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // The upper half is driven zero; software must not rely on it.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      csr_rdata_o <= 32'h0000_0000;
    else if (csr_rd_i)
      csr_rdata_o <= {16'h0000, next_rdata};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      csr_rd_ack_o <= 1'b0;
    else
      csr_rd_ack_o <= csr_rd_i;
  end

endmodule : phy_status_id_autoneg_regs

// File: verification/phy_status_id_autoneg_regs_sva.sv
`timescale 1ns/100ps
module phy_status_id_autoneg_regs_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] csr_addr_i,
  input wire logic csr_rd_i,
  input wire logic csr_wr_i,
  input wire logic [31:0] csr_wdata_i,
  input wire logic [31:0] csr_rdata_o,
  input wire logic csr_rd_ack_o,
  input wire logic xcvr_reset_i,
  input wire logic autoneg_restart_i,
  input wire logic autoneg_done_i,
  input wire logic remote_fault_i,
  input wire logic link_up_i,
  input wire logic jabber_i,
  input wire logic speed_10_i,
  input wire logic [15:0] adv_word_o
);
  // A status read is what clears the latched flags.
  logic sr;
  logic [15:0] wlow;
  assign sr = csr_rd_i && csr_addr_i == phy_regs_pkg::status_offset;
  assign wlow = csr_wdata_i[15:0];
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////
  sequence s_fault;
    remote_fault_i ##1 sr;
  endsequence
  sequence s_loss;
    !link_up_i ##1 sr;
  endsequence
  sequence s_jab;
    (jabber_i && speed_10_i) ##1 sr;
  endsequence
  // Done is held a few cycles so either pipelining of the flag passes.
  sequence s_done;
    (autoneg_done_i && !autoneg_restart_i && !xcvr_reset_i)[*3] ##1 sr;
  endsequence
  property p_upper;
    csr_rd_i |=> csr_rd_ack_o && csr_rdata_o[31:16] == 16'h0000;
  endproperty
  property p_const;
    sr |=> csr_rdata_o[12:11] == 2'b11 && csr_rdata_o[3] && csr_rdata_o[0];
  endproperty
  property p_fault;
    s_fault |=> csr_rdata_o[4];
  endproperty
  property p_link;
    s_loss |=> !csr_rdata_o[2];
  endproperty
  property p_jab;
    s_jab |=> csr_rdata_o[1];
  endproperty
  property p_done;
    s_done |=> csr_rdata_o[5];
  endproperty
  property p_adv;
    adv_word_o[15] == 1'b0 && adv_word_o[9] == 1'b0 &&
      adv_word_o[4:0] == phy_regs_pkg::selector_field;
  endproperty
  property p_wr;
    csr_wr_i && csr_addr_i == phy_regs_pkg::adv_offset && !xcvr_reset_i |=>
      adv_word_o == (($past(wlow) & phy_regs_pkg::adv_write_mask) |
      ($past(adv_word_o) & ~phy_regs_pkg::adv_write_mask));
  endproperty
  a_upper: assert property (p_upper) else $error("upper half");
  a_const: assert property (p_const) else $error("constants");
  a_fault: assert property (p_fault) else $error("fault not latched");
  a_link: assert property (p_link) else $error("link loss not latched");
  a_jab: assert property (p_jab) else $error("jabber not latched");
  a_done: assert property (p_done) else $error("completion not shown");
  a_adv: assert property (p_adv) else $error("fixed advert bits");
  a_wr: assert property (p_wr) else $error("advert write");
endmodule : phy_status_id_autoneg_regs_sva
bind phy_status_id_autoneg_regs phy_status_id_autoneg_regs_sva u_sva (
  .sys_clk_i, .rst_n_i, .csr_addr_i, .csr_rd_i, .csr_wr_i, .csr_wdata_i,
  .csr_rdata_o, .csr_rd_ack_o, .xcvr_reset_i, .autoneg_restart_i,
  .autoneg_done_i, .remote_fault_i, .link_up_i, .jabber_i, .speed_10_i,
  .adv_word_o
);

// File: verification/phy_status_id_autoneg_regs_bench.sv
`timescale 1ns/100ps
module phy_status_id_autoneg_regs_bench;
  localparam logic [15:0] id_hi = 16'h6b21; // Arbitrary value.
  localparam logic [15:0] id_lo = 16'h9c57; // Arbitrary value.
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, csr_rd_i = 1'b0, csr_wr_i = 1'b0;
  logic xcvr_reset_i = 1'b0, autoneg_restart_i = 1'b0, autoneg_done_i = 1'b0;
  logic remote_fault_i = 1'b0, link_up_i = 1'b1, jabber_i = 1'b0;
  logic speed_10_i = 1'b0, partner_word_valid_i = 1'b0;
  logic [7:0] csr_addr_i = 8'h00;
  logic [15:0] partner_word_i = 16'h0000;
  logic [31:0] csr_wdata_i = 32'h00000000;
  logic [31:0] csr_rdata_o, rv;
  logic [15:0] adv_word_o;
  logic csr_rd_ack_o, autoneg_complete_o;
  int err_count = 0;
  int tests_run = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  phy_status_id_autoneg_regs #(.oui_upper_bits(id_hi),
    .oui_lower_bits(id_lo[15:10]), .model_number(id_lo[9:4]),
    .revision_number(id_lo[3:0])) dut (.sys_clk_i, .rst_n_i, .csr_addr_i,
    .csr_rd_i, .csr_wr_i, .csr_wdata_i, .csr_rdata_o, .csr_rd_ack_o,
    .xcvr_reset_i, .autoneg_restart_i, .autoneg_done_i, .remote_fault_i,
    .link_up_i, .jabber_i, .speed_10_i, .partner_word_valid_i,
    .partner_word_i, .adv_word_o, .autoneg_complete_o);
  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i) #1;
    csr_addr_i = a;
    csr_wdata_i = d;
    csr_wr_i = 1'b1;
    @(posedge sys_clk_i) #1;
    csr_wr_i = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge sys_clk_i) #1;
    csr_addr_i = a;
    csr_rd_i = 1'b1;
    @(posedge sys_clk_i) #1;
    csr_rd_i = 1'b0;
    for (n = 0; n < 4 && csr_rd_ack_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
    if (n == 4)
    begin
      err_count++;
      complete_run();
    end
    rv = csr_rdata_o;
  endtask : rd_reg
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rd_reg(8'hb8);
    chk("stat", rv & 32'hffff1fff, 32'h0000180d);
    rd_reg(8'hbc);
    chk("id_high", rv, {16'h0000, id_hi});
    rd_reg(8'hc0);
    chk("id_low", rv, {16'h0000, id_lo});
    rd_reg(8'hc4);
    chk("advert", rv, 32'h000005e1);
    rd_reg(8'hc8);
    chk("partner", rv, 32'h00000000);
    rd_reg(8'hd0);
    chk("unmapped", rv, 32'h00000000);
    $display("reset values done");
    wr_reg(8'hc4, 32'hffffffff);
    rd_reg(8'hc4);
    chk("advert_set", rv, 32'h000025e1);
    wr_reg(8'hc4, 32'h00000000);
    chk("advert_word", {16'h0000, adv_word_o}, 32'h00000001);
    wr_reg(8'hbc, 32'hffffffff);
    rd_reg(8'hbc);
    chk("id_write", rv, {16'h0000, id_hi});
    $display("writes done");
    // Events stay up into the read so set must win over the clear.
    speed_10_i = 1'b1;
    remote_fault_i = 1'b1;
    jabber_i = 1'b1;
    link_up_i = 1'b0;
    rd_reg(8'hb8);
    chk("latch_a", rv & 32'h0000001f, 32'h0000001b);
    remote_fault_i = 1'b0;
    jabber_i = 1'b0;
    link_up_i = 1'b1;
    rd_reg(8'hb8);
    chk("latch_b", rv & 32'h0000001f, 32'h0000001b);
    rd_reg(8'hb8);
    chk("latch_c", rv & 32'h0000001f, 32'h0000000d);
    speed_10_i = 1'b0;
    jabber_i = 1'b1;
    rd_reg(8'hb8);
    chk("jabber_fast", rv & 32'h00000002, 32'h00000000);
    jabber_i = 1'b0;
    $display("latches done");
    autoneg_done_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1 rd_reg(8'hb8);
    chk("complete", rv & 32'h00000020, 32'h00000020);
    partner_word_i = 16'hffff;
    partner_word_valid_i = 1'b1;
    @(posedge sys_clk_i) #1;
    partner_word_valid_i = 1'b0;
    rd_reg(8'hc8);
    chk("partner_load", rv, 32'h0000e7ff);
    autoneg_done_i = 1'b0;
    autoneg_restart_i = 1'b1;
    @(posedge sys_clk_i) #1;
    autoneg_restart_i = 1'b0;
    rd_reg(8'hc8);
    chk("partner_clr", rv, 32'h00000000);
    chk("complete_o", {31'h0, autoneg_complete_o}, 32'h00000000);
    xcvr_reset_i = 1'b1;
    @(posedge sys_clk_i) #1;
    xcvr_reset_i = 1'b0;
    rd_reg(8'hc4);
    chk("advert_rst", rv, 32'h000005e1);
    $display("negotiation done");
    complete_run();
  end
endmodule : phy_status_id_autoneg_regs_bench
